/* File: mac_accumulate.sv */
// Accumulator, preload, signed MAC and result read of the coprocessor.
// Assumes the core issues mode writes and transfers as single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// RULE1 - Writing mode 0 clears the whole accumulator at once, with no transfer.
// RULE2 - Mode 1 preload zeroes the upper half and loads the source into the lower half.
// RULE3 - Mode 2 preload loads destination into the upper half and source into the lower.
// RULE4 - Mode 7 transfers add the signed product of the operands to the accumulator.
// RULE5 - A MAC transfer returns the lower half in mode 07 or the upper half in 17.
// RULE6 - Overflow is flagged as pattern 0100 when like-signed addends give an unlike sum.
// RULE7 - Carry, zero and negative return zero on MAC, and 0000 with no overflow.
// RULE8 - The MAC mode stays set across successive calculation transfers.
// RULE9 - A held overflow flag clears on a clean MAC step or any non-read-mode transfer.
// RULE10 - Read mode returns the selected half, zero flags, and leaves the accumulator.
// RULE11 - The accumulator holds its value until a later operation rewrites it.
// RULE12 - The core initialises the accumulator before starting an accumulation.
// RULE13 - The core writes the mode before the transfers that depend on it.
// RULE14 - Mode bits 3..0 select the operation and bit 4 selects the upper half.
module mac_accumulate
    import mac_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 coproc_mode_write,
    input  wire logic [MODE_W-1:0]    mode_in,
    input  wire logic                 coproc_calc_transfer,
    input  wire logic                 coproc_preload_transfer,
    input  wire operand_type          operands,
    output result_type                result,
    output logic                      result_valid,
    output logic                      overflow_held,
    output logic [ACC_W-1:0]          acc_value,
    output logic [MODE_W-1:0]         mode_value
);

    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;
    logic [ACC_W-1:0]  acc_q;
    logic [ACC_W-1:0]  acc_d;
    result_type        result_q;
    result_type        result_d;
    logic              valid_q;
    logic              ovf_q;
    logic              ovf_d;

    wire logic [3:0] op_sel    = mode_q[OP_MSB:OP_LSB];           // [RULE14]
    wire logic       upper_sel = mode_q[HALF_BIT];                // [RULE14]
    wire logic       is_mac    = (op_sel == OP_MAC);
    wire logic       is_read   = (op_sel == OP_READ);
    wire logic       is_load16 = (op_sel == OP_LOAD16);
    wire logic       is_load32 = (op_sel == OP_LOAD32);
    wire logic       clr_write = coproc_mode_write
                                 && (mode_in[OP_MSB:OP_LSB] == OP_CLEAR);

    wire logic signed [ACC_W-1:0] product;
    mac_mul #(
        .W (DATA_W)
    ) u_mul (
        .a (operands.dst),
        .b (operands.src),
        .p (product)
    );

    // Wraps on overflow; the flag, not saturation, reports it
    wire logic [ACC_W-1:0] mac_sum = acc_q + product;             // [RULE4]
    wire logic p_neg   = product[ACC_W-1];
    wire logic a_neg   = acc_q[ACC_W-1];
    wire logic s_neg   = mac_sum[ACC_W-1];
    wire logic mac_ovf = (!p_neg && !a_neg && s_neg)
                         || (p_neg && a_neg && !s_neg);           // [RULE6]

    wire logic mac_go   = coproc_calc_transfer && is_mac;
    wire logic pre16_go = coproc_preload_transfer && is_load16;
    wire logic pre32_go = coproc_preload_transfer && is_load32;

    wire logic [ACC_W-1:0] pre16_val = {{DATA_W{1'b0}}, operands.src}; // [RULE2]
    wire logic [ACC_W-1:0] pre32_val = {operands.dst, operands.src};   // [RULE3]

    // Mode holds until the next mode write, so MAC steps repeat freely
    assign mode_d = coproc_mode_write ? mode_in : mode_q;         // [RULE8]

    // Other modes (multiply, divide) live elsewhere; here they leave the value
    assign acc_d = clr_write ? ACC_RESET :                        // [RULE1]
                   pre32_go  ? pre32_val :                        // [RULE3]
                   pre16_go  ? pre16_val :                        // [RULE2]
                   mac_go    ? mac_sum   :                        // [RULE4]
                   acc_q;                                         // [RULE11] [RULE10]

    wire logic [ACC_W-1:0] ret_src = mac_go ? mac_sum : acc_q;
    wire logic [DATA_W-1:0] ret_half = upper_sel ? ret_src[ACC_W-1:DATA_W]
                                                 : ret_src[DATA_W-1:0]; // [RULE5] [RULE10]

    wire logic [3:0] ret_flags = (mac_go && mac_ovf) ? FLAGS_OVF
                                                     : FLAGS_NONE; // [RULE7] [RULE10]

    always_comb begin
        result_d = result_q;
        if (coproc_calc_transfer) begin
            result_d.data  = ret_half;
            result_d.flags = ret_flags;
        end
    end

    // Any transfer outside read mode replaces the held overflow state
    wire logic xfer_nonread = (coproc_calc_transfer || coproc_preload_transfer)
                              && !is_read;
    assign ovf_d = xfer_nonread ? (mac_go && mac_ovf) : ovf_q;   // [RULE9] [RULE6]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    // One-cycle answer strobe for every calculation transfer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= coproc_calc_transfer;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    assign result        = result_q;
    assign result_valid  = valid_q;
    assign overflow_held = ovf_q;
    assign acc_value     = acc_q;
    assign mode_value    = mode_q;

endmodule // mac_accumulate
`default_nettype wire

/* File: mac_pkg.sv */
// Shared constants and carriers for the coprocessor accumulate and result-read block.
// Assumes a single core clock and transfers presented as one-cycle strobes.
package mac_pkg;

    localparam int DATA_W = 16;
    localparam int ACC_W  = 32;
    localparam int MODE_W = 5;

    localparam logic [3:0] OP_CLEAR   = 4'h0;
    localparam logic [3:0] OP_LOAD16  = 4'h1;
    localparam logic [3:0] OP_LOAD32  = 4'h2;
    localparam logic [3:0] OP_READ    = 4'h3;
    localparam logic [3:0] OP_MULU    = 4'h4;
    localparam logic [3:0] OP_MULS    = 4'h5;
    localparam logic [3:0] OP_MAC     = 4'h7;
    localparam logic [3:0] OP_DIVU    = 4'h8;
    localparam logic [3:0] OP_DIVS    = 4'h9;

    localparam int OP_LSB    = 0;
    localparam int OP_MSB    = 3;
    localparam int HALF_BIT  = 4;

    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
    localparam logic [ACC_W-1:0]  ACC_RESET  = 32'h0000_0000;
    localparam logic [3:0]        FLAGS_NONE = 4'h0;
    localparam logic [3:0]        FLAGS_OVF  = 4'h4;

    typedef struct packed {
        logic [DATA_W-1:0] dst;
        logic [DATA_W-1:0] src;
    } operand_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [3:0]        flags;
    } result_type;

endpackage

/* File: mac_mul.sv */
// Registered-free signed 16x16 multiplier feeding the accumulator adder.
// Assumes operands are two's complement.
`timescale 1ns/1ps
`default_nettype none
module mac_mul #(
    parameter int W = 16
) (
    input  wire logic signed [W-1:0]   a,
    input  wire logic signed [W-1:0]   b,
    output logic signed [2*W-1:0]      p
);
    assign p = a * b;
endmodule // mac_mul
`default_nettype wire

/* File: mac_accumulate_assertions.sv */
// Port checker for the accumulate block.
// Sees the block's ports only; one clock.
`timescale 1ns/1ps
`default_nettype none
module mac_accumulate_assertions
    import mac_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              coproc_mode_write,
    input wire logic [MODE_W-1:0] mode_in,
    input wire logic              coproc_calc_transfer,
    input wire logic              coproc_preload_transfer,
    input wire operand_type       operands,
    input wire result_type        result,
    input wire logic              result_valid,
    input wire logic              overflow_held,
    input wire logic [ACC_W-1:0]  acc_value,
    input wire logic [MODE_W-1:0] mode_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic [3:0] op = mode_value[3:0];
    wire logic [31:0] a = acc_value;
    wire logic clr = coproc_mode_write && mode_in[3:0] == OP_CLEAR;
    wire logic ca = coproc_calc_transfer && !clr;
    wire logic upd = (ca || coproc_preload_transfer) && !clr && op != OP_READ;
    wire logic signed [31:0] prod = $signed(operands.dst) * $signed(operands.src);
    wire logic [31:0] sum = a + prod;
    // Overflow only when like-signed addends give an unlike sum
    wire logic vf = ca && op == OP_MAC && prod[31] == a[31] && sum[31] != a[31];
    wire logic [15:0] half = mode_value[HALF_BIT] ? a[31:16] : a[15:0];
    wire logic idle = !coproc_mode_write && !coproc_preload_transfer && !(ca && op != OP_READ);
    sequence ld(logic [3:0] k); coproc_preload_transfer && !clr && op == k; endsequence
    AST_CLR: assert property (clr |=> a == ACC_RESET) else $error("clr");
    AST_LD16: assert property (ld(OP_LOAD16) |=> a == $past(operands.src))
        else $error("ld16");
    AST_LD32: assert property (ld(OP_LOAD32) |=> a == $past(operands))
        else $error("ld32");
    AST_MAC: assert property (ca && op == OP_MAC |=> a == $past(sum))
        else $error("mac");
    AST_FLG: assert property (ca |=>
        result.flags == ($past(vf) ? FLAGS_OVF : FLAGS_NONE)) else $error("flg");
    AST_HALF: assert property (result_valid && !$past(coproc_mode_write) |->
        result.data == half) else $error("half");
    AST_HOLD: assert property (idle |=> $stable(a)) else $error("hold");
    AST_OVF: assert property (upd |=> overflow_held == $past(vf)) else $error("ovf");
    AST_VLD: assert property (result_valid == $past(coproc_calc_transfer))
        else $error("vld");
endmodule // mac_accumulate_assertions
bind mac_accumulate mac_accumulate_assertions chk (.*);
`default_nettype wire

/* File: mac_core_model.sv */
// Core stand-in issuing mode writes and transfers.
// Block answers one cycle after each strobe.
`timescale 1ns/1ps
`default_nettype none
module mac_core_model import mac_pkg::*; (
    input wire logic          sys_clk,
    output logic              mode_write,
    output logic [MODE_W-1:0] mode,
    output logic              calc,
    output logic              preload,
    output operand_type       ops
);
    initial {mode_write, mode, calc, preload, ops} = '0;
    // Callers write the mode and the initial value first
    task xfer(input logic [2:0] k, input logic [4:0] m, input logic [31:0] v);
        @(posedge sys_clk);
        #1 {mode_write, calc, preload} = k;
        {mode, ops} = {m, v};
        @(posedge sys_clk);
        #1 {mode_write, calc, preload} = 3'h0;
        ops = ~v; // Released operands must not look valid
    endtask
endmodule // mac_core_model
`default_nettype wire

/* File: mac_accumulate_tb.sv */
// Bench for the accumulate block.
// Drives it through the core model.
`timescale 1ns/1ps
`default_nettype none
module mac_accumulate_tb import mac_pkg::*;;
    logic sys_clk = 1'h0, rst = 1'h1, rv, ovh;
    wire logic mw, ca, cf;
    wire logic [4:0] mi, mv;
    wire operand_type ops;
    result_type res;
    logic [31:0] acc;
    int n_mismatch = 0, cmp_count = 0;
    initial forever #4 sys_clk = ~sys_clk;
    mac_core_model core (.sys_clk, .mode_write(mw), .mode(mi), .calc(ca), .preload(cf), .ops);
    mac_accumulate dut (.sys_clk, .rst, .coproc_mode_write(mw), .mode_in(mi),
        .coproc_calc_transfer(ca), .coproc_preload_transfer(cf), .operands(ops), .result(res),
        .result_valid(rv), .overflow_held(ovh), .acc_value(acc), .mode_value(mv));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task init;
        core.xfer(3'h4, 5'h02, 32'h0);
        core.xfer(3'h1, 5'h02, 32'h1234_5678);
        chk(acc, 32'h1234_5678);
        core.xfer(3'h4, 5'h01, 32'h0);
        core.xfer(3'h1, 5'h01, 32'hFFFF_ABCD);
        chk(acc, 32'h0000_ABCD);
        core.xfer(3'h4, 5'h00, 32'h0);
        chk({mv, acc}, 37'h0);
    endtask
    task mac;
        core.xfer(3'h4, 5'h07, 32'h0);
        core.xfer(3'h2, 5'h07, 32'h0003_0004);
        chk({rv, res}, {1'h1, 16'h000C, FLAGS_NONE});
        core.xfer(3'h2, 5'h07, 32'hFFFE_0005);
        chk(acc, 32'h0000_0002);
        core.xfer(3'h4, 5'h17, 32'h0);
        core.xfer(3'h2, 5'h17, 32'hFFFF_0100);
        chk({res, acc}, {16'hFFFF, FLAGS_NONE, 32'hFFFF_FF02});
    endtask
    task ovf;
        core.xfer(3'h4, 5'h02, 32'h0);
        core.xfer(3'h1, 5'h02, 32'h7FFF_FFFF);
        core.xfer(3'h4, 5'h07, 32'h0);
        core.xfer(3'h2, 5'h07, 32'h0001_0001);
        chk({ovh, res}, {1'h1, 16'h0000, FLAGS_OVF});
        core.xfer(3'h4, 5'h13, 32'h0);
        core.xfer(3'h2, 5'h13, 32'h0);
        chk({ovh, res, acc}, {1'h1, 16'h8000, FLAGS_NONE, 32'h8000_0000});
        core.xfer(3'h4, 5'h07, 32'h0);
        core.xfer(3'h1, 5'h07, 32'h0);
        chk({ovh, acc}, {1'h0, 32'h8000_0000});
    endtask
    task ovf_neg;
        core.xfer(3'h4, 5'h02, 32'h0);
        core.xfer(3'h1, 5'h02, 32'h8000_0000);
        core.xfer(3'h4, 5'h07, 32'h0);
        core.xfer(3'h2, 5'h07, 32'hFFFF_0001);
        chk({ovh, res, acc}, {1'h1, 16'hFFFF, FLAGS_OVF, 32'h7FFF_FFFF});
        core.xfer(3'h2, 5'h07, 32'h0);
        chk({ovh, res, acc}, {1'h0, 16'hFFFF, FLAGS_NONE, 32'h7FFF_FFFF});
    endtask
    task read_lo;
        core.xfer(3'h4, 5'h03, 32'h0);
        core.xfer(3'h2, 5'h03, 32'h0001_0001);
        chk({rv, res, acc}, {1'h1, 16'hFFFF, FLAGS_NONE, 32'h7FFF_FFFF});
        @(posedge sys_clk);
        #1 chk({rv, res}, {1'h0, 16'hFFFF, FLAGS_NONE});
    endtask
    task reset_mid;
        core.xfer(3'h4, 5'h17, 32'h0);
        core.xfer(3'h2, 5'h17, 32'h0001_0001);
        chk({ovh, res}, {1'h1, 16'h8000, FLAGS_OVF});
        @(posedge sys_clk);
        #1 rst = 1'h1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'h0;
        chk({rv, ovh, res, acc, mv}, 59'h0);
        core.xfer(3'h4, 5'h07, 32'h0);
        core.xfer(3'h2, 5'h07, 32'h0002_0003);
        chk({rv, res, acc}, {1'h1, 16'h0006, FLAGS_NONE, 32'h0000_0006});
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'h0;
        init;
        mac;
        ovf;
        ovf_neg;
        read_lo;
        reset_mid;
        tally_and_finish;
    end
    initial begin
        #5000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // mac_accumulate_tb
`default_nettype wire
